// ---- src/section_crc32_checker.v ----
`timescale 1ns/1ps
`default_nettype none
`include "crc_defines.vh"
// Section CRC checker: bytes buffered, then shifted one bit per clock
module section_crc32_checker #(
  parameter FIFO_DEPTH = `CRC_FIFO_DEPTH,
  parameter FIFO_AW = 5
) (
  // Clock and reset
  input wire MCLK_IN,
  input wire RESETN_IN,
  // Byte stream in
  input wire SOS_IN,
  input wire [7:0] BYTE_IN,
  input wire LAST_IN,
  input wire VALID_IN,
  output wire READY_OUT,
  // Result
  output reg RESULT_VALID_OUT,
  output reg PASS_OUT,
  output reg [31:0] REMAINDER_OUT,
  output reg BUSY_OUT
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  reg rst_meta_reg;
  reg rst_sync_reg;
  reg state_reg;
  reg [31:0] crc_reg;
  reg [7:0] shift_reg;
  reg [2:0] bitcnt_reg;
  reg last_reg;
  reg ready_reg;
  reg [FIFO_AW:0] occ_reg;
  reg [FIFO_AW:0] occ_next;
  wire push;
  wire pop;
  wire [8:0] fifo_out;
  wire fifo_valid;
  wire fifo_ready;
  wire fifo_wr_ready;
  wire [31:0] crc_next;
  wire [8:0] fifo_in;

  // Reset release through two flops
  always @(posedge MCLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Handshakes seen from outside and from the shifter
  assign push = VALID_IN && ready_reg;
  assign pop = fifo_valid && fifo_ready;

  // Occupancy one cycle ahead, so a registered ready never overfills
  always @*
  begin
    occ_next = occ_reg;
    if (push && !pop)
      occ_next = occ_reg + 1'b1;
    else if (pop && !push)
      occ_next = occ_reg - 1'b1;
  end

  // Ready register; SOS bypasses FIFO so it does not enter it
  always @(posedge MCLK_IN or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      ready_reg <= 1'b0;
      occ_reg <= {(FIFO_AW+1){1'b0}};
    end
    else
    begin
      occ_reg <= occ_next;
      ready_reg <= (occ_next != FIFO_DEPTH[FIFO_AW:0]);
    end
  end
  assign READY_OUT = ready_reg;

  assign fifo_in = {LAST_IN, BYTE_IN};

  crc_byte_fifo #(
    .WIDTH(`CRC_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(MCLK_IN),
    .rst_n(rst_sync_reg),
    .wr_data(fifo_in),
    .wr_valid(push),
    .wr_ready(fifo_wr_ready),
    .rd_data(fifo_out),
    .rd_valid(fifo_valid),
    .rd_ready(fifo_ready)
  );

  // Take a byte only when the shifter is idle
  assign fifo_ready = (state_reg == ST_IDLE) && !SOS_IN;

  crc_lfsr_step u_step (
    .stages_in(crc_reg),
    .bit_in(shift_reg[7]),
    .stages_out(crc_next)
  );

  // Shifter and result logic, one bit per clock
  always @(posedge MCLK_IN or negedge rst_sync_reg)
  begin
    if (!rst_sync_reg)
    begin
      state_reg <= ST_IDLE;
      crc_reg <= `CRC_PRESET;
      shift_reg <= 8'h00;
      bitcnt_reg <= 3'h0;
      last_reg <= 1'b0;
      RESULT_VALID_OUT <= 1'b0;
      PASS_OUT <= 1'b0;
      REMAINDER_OUT <= 32'h00000000;
      BUSY_OUT <= 1'b0;
    end
    else
    begin
      RESULT_VALID_OUT <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (SOS_IN)
            crc_reg <= `CRC_PRESET;
          else if (fifo_valid)
          begin
            shift_reg <= fifo_out[7:0];
            last_reg <= fifo_out[8];
            bitcnt_reg <= 3'h0;
            state_reg <= ST_SHIFT;
            BUSY_OUT <= 1'b1;
          end
          else
            BUSY_OUT <= 1'b0;
        end
        ST_SHIFT:
        begin
          crc_reg <= crc_next;
          shift_reg <= {shift_reg[6:0], 1'b0};
          bitcnt_reg <= bitcnt_reg + 3'h1;
          if (bitcnt_reg == 3'h7)
          begin
            state_reg <= ST_IDLE;
            BUSY_OUT <= fifo_valid;
            if (last_reg)
            begin
              // Judge after final bit enters stage 0
              RESULT_VALID_OUT <= 1'b1;
              PASS_OUT <= (crc_next == 32'h00000000);
              REMAINDER_OUT <= crc_next;
              crc_reg <= `CRC_PRESET;
            end
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- src/crc_defines.vh ----
`ifndef CRC_DEFINES_VH
`define CRC_DEFINES_VH
`define CRC_WIDTH 32
`define CRC_TAPS 32'h04c11db7
`define CRC_PRESET 32'hffffffff
`define CRC_BYTE_BITS 8
`define CRC_FIFO_DEPTH 32
`define CRC_FIFO_WIDTH 9
`endif

// ---- src/crc_byte_fifo.v ----
`timescale 1ns/1ps
`default_nettype none
// Synchronous FIFO, word is {last, data}
module crc_byte_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  output wire [WIDTH-1:0] rd_data,
  output wire rd_valid,
  input wire rd_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;

  // Honest flags from occupancy
  assign wr_ready = (count_reg != DEPTH[AW:0]);
  assign rd_valid = (count_reg != {(AW+1){1'b0}});
  assign rd_data = mem[rptr_reg];
  assign do_wr = wr_valid && wr_ready;
  assign do_rd = rd_valid && rd_ready;

  // Storage write
  always @(posedge clk)
  begin
    if (do_wr)
      mem[wptr_reg] <= wr_data;
  end

  // Pointers and count
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wptr_reg <= (wptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wptr_reg + 1'b1;
      if (do_rd)
        rptr_reg <= (rptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rptr_reg + 1'b1;
      if (do_wr && !do_rd)
        count_reg <= count_reg + 1'b1;
      else if (do_rd && !do_wr)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- src/crc_lfsr_step.v ----
`timescale 1ns/1ps
`default_nettype none
`include "crc_defines.vh"
// One bit step of the 32-stage decoder shift register
module crc_lfsr_step #(
  parameter [31:0] TAPS = `CRC_TAPS
) (
  input wire [31:0] stages_in,
  input wire bit_in,
  output wire [31:0] stages_out
);
  wire fb;

  // Input plus last stage output
  assign fb = bit_in ^ stages_in[31];
  // Shift; adders where the tap bit is set
  assign stages_out = {stages_in[30:0], 1'b0} ^ (TAPS & {32{fb}});
endmodule
`default_nettype wire

// ---- testbench/crc_res_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module crc_res_checker (
  input wire MCLK_IN,
  input wire RESETN_IN,
  input wire VALID_IN,
  input wire LAST_IN,
  input wire READY_OUT,
  input wire RESULT_VALID_OUT,
  input wire PASS_OUT,
  input wire [31:0] REMAINDER_OUT,
  input wire BUSY_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // Handshake of the final check byte
  sequence last_taken;
    VALID_IN && READY_OUT && LAST_IN;
  endsequence
  verdict_a: assert property (
    RESULT_VALID_OUT |-> PASS_OUT == (REMAINDER_OUT == 32'h0)) else $error("v");
  zero_a: assert property (
    PASS_OUT |-> REMAINDER_OUT == 32'h0) else $error("z");
  pulse_a: assert property (
    RESULT_VALID_OUT |=> !RESULT_VALID_OUT) else $error("p");
  pass_hold_a: assert property (
    !RESULT_VALID_OUT |-> $stable(PASS_OUT)) else $error("h");
  rem_hold_a: assert property (
    !RESULT_VALID_OUT |-> $stable(REMAINDER_OUT)) else $error("r");
  serial_a: assert property (
    RESULT_VALID_OUT |-> $past(BUSY_OUT, 8)) else $error("s");
  done_a: assert property (
    last_taken |-> ##[8:400] RESULT_VALID_OUT) else $error("d");
  early_a: assert property (
    last_taken |=> !RESULT_VALID_OUT [*7]) else $error("e");
endmodule
bind section_crc32_checker crc_res_checker chk (.MCLK_IN(MCLK_IN),
  .RESETN_IN(RESETN_IN), .VALID_IN(VALID_IN), .LAST_IN(LAST_IN),
  .READY_OUT(READY_OUT), .RESULT_VALID_OUT(RESULT_VALID_OUT),
  .PASS_OUT(PASS_OUT), .REMAINDER_OUT(REMAINDER_OUT), .BUSY_OUT(BUSY_OUT));
`default_nettype wire

// ---- testbench/section_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module section_source (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [7:0] byte_out,
  output logic last_out
);
  // Hold each byte until taken
  task automatic send(input logic [7:0] b, input logic l, output bit ok);
    valid_out = 1;
    byte_out = b;
    last_out = l;
    ok = 0;
    for (int k = 0; k < 300 && !ok; k++)
    begin
      @(posedge clk_in);
      ok = (ready_in === 1'b1);
    end
    #1;
  endtask
  // Released lines show no stale byte
  task automatic idle();
    valid_out = 0;
    byte_out = ~byte_out;
    last_out = 0;
  endtask
  initial idle();
endmodule
`default_nettype wire

// ---- testbench/section_crc32_checker_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t result mismatch", $time); end end
module section_crc32_checker_tb;
  logic clk = 0, rst_n = 0, sos = 0, rdy, vld, lst, rv, ps, bsy;
  logic [7:0] byt;
  logic [31:0] rem;
  int n_mismatch = 0, num_checks = 0;
  initial forever #2 clk = ~clk;
  section_crc32_checker dut (.MCLK_IN(clk), .RESETN_IN(rst_n), .SOS_IN(sos),
    .BYTE_IN(byt), .LAST_IN(lst), .VALID_IN(vld), .READY_OUT(rdy),
    .RESULT_VALID_OUT(rv), .PASS_OUT(ps), .REMAINDER_OUT(rem), .BUSY_OUT(bsy));
  section_source src (.clk_in(clk), .ready_in(rdy), .valid_out(vld),
    .byte_out(byt), .last_out(lst));
  // Reference shift register, msb first
  function automatic logic [31:0] crc(logic [31:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04c11db7 : 32'h0);
    return c;
  endfunction
  task end_of_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One section: n data bytes, check field, optional flipped bit
  task automatic run(int n, logic [7:0] flip);
    logic [7:0] d[$];
    logic [31:0] c;
    bit ok;
    int k;
    c = 32'hffffffff;
    for (int i = 0; i < n; i++)
    begin
      d.push_back(8'(i * 37 + 1));
      c = crc(c, d[i]);
    end
    for (int i = 3; i >= 0; i--)
      d.push_back(c[i*8 +: 8]);
    d[d.size() - 1] ^= flip;
    c = 32'hffffffff;
    foreach (d[i])
      c = crc(c, d[i]);
    sos = 1;
    @(posedge clk);
    #1 sos = 0;
    foreach (d[i])
    begin
      src.send(d[i], i == d.size() - 1, ok);
      if (!ok)
      begin
        n_mismatch++;
        end_of_test();
      end
    end
    src.idle();
    for (k = 0; k < 400 && rv !== 1'b1; k++)
      @(posedge clk) #1;
    if (k == 400)
    begin
      n_mismatch++;
      end_of_test();
    end
    `CHK(ps, c == 0)
    `CHK(rem, c)
  endtask
  task t_good; run(8, 8'h00); endtask
  task t_bad_lsb; run(8, 8'h01); endtask
  task t_check_only; run(0, 8'h00); endtask
  task t_long; run(26, 8'h00); endtask
  task t_bad_msb; run(3, 8'h80); endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    repeat (8) @(posedge clk);
    #1;
    t_good();
    t_bad_lsb();
    t_check_only();
    t_long();
    t_bad_msb();
    t_good();
    end_of_test();
  end
endmodule
`default_nettype wire
